// *** src/psrm_pkg.sv ***
// Summary of operation
// - Pad enable is override OR peripheral enable
// - Only serial, two-wire, timer outputs supply enable
// - Pull-up force bit enables pad pull-up
// - Pull-down force bit enables pad pull-down
// - Pad override bits are independent, any combination
// - High-drive pins never pull or go analog
// - Eight-bit mask picks affected pins of port
// - Each peripheral input has own pin select
// - Twenty-one routable peripheral inputs as listed
// - Input select is one-hot pin within port
// - Per-pin output select, many pins at once
// - Twenty-one selectable peripheral outputs as listed
// - Force-off follows peripheral, else override settings
// - Thirty-two pins as four ports of eight
// - Single pin pad configuration is readable
package psrm_pkg;
  localparam int NUM_PORTS = 4;
  localparam int PINS_PER_PORT = 8;
  localparam int NUM_PINS = NUM_PORTS * PINS_PER_PORT;
  localparam int NUM_IN = 21;
  localparam int NUM_OUT = 21;
  localparam int SEL_W = 5;
  localparam logic [1:0] HIGH_DRIVE_PORT = 2'h2;
  localparam int HIGH_DRIVE_PIN_FIRST = 0;
  localparam int HIGH_DRIVE_PIN_LAST = 3;
  // Output select codes: 0 means no peripheral, code k drives peripheral output k-1
  localparam logic [SEL_W-1:0] OUT_SEL_NONE = 5'h00;
  localparam logic [SEL_W-1:0] OUT_SEL_MAX = 5'h15;
  // Outputs 3..20 are serial ports, two-wire and timers; the UARTs carry no enable
  localparam logic [NUM_OUT-1:0] OE_CAPABLE = 21'h1ffff8;
  // Override field positions inside the command data word
  localparam int OVR_OE_POS = 0;
  localparam int OVR_PUE_POS = 1;
  localparam int OVR_PDE_POS = 2;
  localparam int OVR_ANA_POS = 3;
  localparam int OVR_DIS_POS = 4;

  typedef struct packed {
    logic forceOff;
    logic analogForce;
    logic pulldownForce;
    logic pullupForce;
    logic outEnForce;
  } psrm_override_t;

  typedef struct packed {
    logic [1:0] port;
    logic [PINS_PER_PORT-1:0] pinMask;
  } psrm_in_sel_t;

  typedef enum logic [1:0] {
    OP_PAD_SET = 2'h0,
    OP_PAD_GET = 2'h1,
    OP_IN_ROUTE = 2'h2,
    OP_OUT_ROUTE = 2'h3
  } psrm_op_t;

  typedef struct packed {
    psrm_op_t op;
    logic [1:0] port;
    logic [PINS_PER_PORT-1:0] portPinMask;
    logic [SEL_W-1:0] data;
  } psrm_cmd_t;

  localparam psrm_override_t OVR_RESET = '0;
  localparam psrm_in_sel_t IN_SEL_RESET = '0;
  localparam logic [SEL_W-1:0] OUT_SEL_RESET = OUT_SEL_NONE;
endpackage

// *** src/psrm_pad_cell.sv ***
`timescale 1ns/1ns
module psrm_pad_cell #(
  parameter bit HIGH_DRIVE = 1'b0
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic wrPad, // Load override bits
  input wire logic wrRoute, // Load output select
  input wire psrm_pkg::psrm_override_t cfgIn, // Override bits to load
  input wire logic [psrm_pkg::SEL_W-1:0] routeIn, // Output select to load
  input wire logic [psrm_pkg::NUM_OUT-1:0] periphOut, // Peripheral output values
  input wire logic [psrm_pkg::NUM_OUT-1:0] periphOe, // Peripheral output enables
  input wire logic gpioOut, // Port data when no peripheral is routed
  input wire logic gpioOe, // Port enable when no peripheral is routed
  output psrm_pkg::psrm_override_t cfg_reg, // Stored override bits
  output logic padOut_reg, // Pad output value
  output logic padOeN_reg, // Pad output enable, low drives
  output logic padPullUp_reg, // Pad pull-up enable
  output logic padPullDown_reg, // Pad pull-down enable
  output logic padAnalog_reg // Pad analog connection
);
  import psrm_pkg::*;

  psrm_override_t cfg_next;
  logic [SEL_W-1:0] route_reg;
  logic [SEL_W-1:0] route_next;
  logic padOut_next;
  logic padOeN_next;
  logic padPullUp_next;
  logic padPullDown_next;
  logic padAnalog_next;
  logic selOut;
  logic selOe;

  always_comb begin
    cfg_next = wrPad ? cfgIn : cfg_reg;
    route_next = wrRoute ? routeIn : route_reg;
    selOut = gpioOut;
    selOe = gpioOe;
    if (route_reg != OUT_SEL_NONE) begin
      selOut = periphOut[route_reg - 5'h01];
      selOe = periphOe[route_reg - 5'h01] & OE_CAPABLE[route_reg - 5'h01];
    end
    padOut_next = selOut;
    if (cfg_reg.forceOff) begin
      // Peripheral keeps full control of the pad
      padOeN_next = ~selOe;
      padPullUp_next = 1'b0;
      padPullDown_next = 1'b0;
      padAnalog_next = 1'b0;
    end else begin
      padOeN_next = ~(cfg_reg.outEnForce | selOe);
      padPullUp_next = cfg_reg.pullupForce & ~HIGH_DRIVE;
      padPullDown_next = cfg_reg.pulldownForce & ~HIGH_DRIVE;
      padAnalog_next = cfg_reg.analogForce & ~HIGH_DRIVE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg <= OVR_RESET;
      route_reg <= OUT_SEL_RESET;
      padOut_reg <= 1'b0;
      padOeN_reg <= 1'b1;
      padPullUp_reg <= 1'b0;
      padPullDown_reg <= 1'b0;
      padAnalog_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      route_reg <= route_next;
      padOut_reg <= padOut_next;
      padOeN_reg <= padOeN_next;
      padPullUp_reg <= padPullUp_next;
      padPullDown_reg <= padPullDown_next;
      padAnalog_reg <= padAnalog_next;
    end
  end
endmodule

// *** src/psrm_routing_matrix.sv ***
`timescale 1ns/1ns
module psrm_routing_matrix (
  input wire logic clk, // System clock, 100 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic cmdValid, // Command strobe
  input wire psrm_pkg::psrm_cmd_t cmd, // Command word
  output logic rdValid_reg, // Readback valid pulse
  output psrm_pkg::psrm_override_t rdData_reg, // Readback override bits
  output logic cmdErr_reg, // Command refused pulse
  input wire logic [psrm_pkg::NUM_PINS-1:0] padIn, // Pad input levels, asynchronous
  input wire logic [psrm_pkg::NUM_PINS-1:0] gpioOut, // Port data per pin
  input wire logic [psrm_pkg::NUM_PINS-1:0] gpioOe, // Port enable per pin
  input wire logic [psrm_pkg::NUM_OUT-1:0] periphOut, // Peripheral output values
  input wire logic [psrm_pkg::NUM_OUT-1:0] periphOe, // Peripheral output enables
  output logic [psrm_pkg::NUM_IN-1:0] periphIn_reg, // Routed peripheral inputs
  output logic [psrm_pkg::NUM_PINS-1:0] padOut, // Pad output values
  output logic [psrm_pkg::NUM_PINS-1:0] padOeN, // Pad enables, low drives
  output logic [psrm_pkg::NUM_PINS-1:0] padPullUp, // Pad pull-up enables
  output logic [psrm_pkg::NUM_PINS-1:0] padPullDown, // Pad pull-down enables
  output logic [psrm_pkg::NUM_PINS-1:0] padAnalog // Pad analog connections
);
  import psrm_pkg::*;

  // Peripheral input order: 0 uart0 rx, 1 uart1 cts, 2 uart1 rx,
  // 3..6 serial port 0 clock, rx data, frame select in, clock in alt,
  // 7..10 the same for serial port 1, 11 two-wire data, 12 two-wire clock,
  // 13..20 timer 0..3 capture inputs a and b
  localparam int PIN_IDX_W = 3;
  localparam int PIN_W = 5;

  function automatic logic isOneHot(input logic [PINS_PER_PORT-1:0] m);
    isOneHot = (m != 8'h00) && ((m & (m - 8'h01)) == 8'h00);
  endfunction

  function automatic logic [PIN_IDX_W-1:0] oneHotIndex(input logic [PINS_PER_PORT-1:0] m);
    oneHotIndex = '0;
    for (int i = 0; i < PINS_PER_PORT; i++) begin
      if (m[i]) begin
        oneHotIndex = PIN_IDX_W'(i);
      end
    end
  endfunction

  function automatic logic [PIN_W-1:0] pinNumber(input logic [1:0] port,
                                                 input logic [PINS_PER_PORT-1:0] m);
    pinNumber = {port, oneHotIndex(m)};
  endfunction

  // Pad inputs come from outside the clock domain
  // A pad change reaches periphIn_reg three edges later
  logic [NUM_PINS-1:0] padSync1_reg;
  logic [NUM_PINS-1:0] padSync2_reg;
  logic [NUM_PINS-1:0] padSync1_next;
  logic [NUM_PINS-1:0] padSync2_next;

  always_comb begin
    padSync1_next = padIn;
    padSync2_next = padSync1_reg;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      padSync1_reg <= '0;
      padSync2_reg <= '0;
    end else begin
      padSync1_reg <= padSync1_next;
      padSync2_reg <= padSync2_next;
    end
  end

  // Command decode
  // Commands need no handshake; a refused one only pulses cmdErr_reg
  logic selOneHot;
  logic outSelLegal;
  logic inIdxLegal;
  logic doPadSet;
  logic doPadGet;
  logic doInRoute;
  logic doOutRoute;
  logic badCmd;
  logic [NUM_PINS-1:0] pinHit;

  always_comb begin
    selOneHot = isOneHot(cmd.portPinMask);
    outSelLegal = cmd.data <= OUT_SEL_MAX;
    inIdxLegal = cmd.data < SEL_W'(NUM_IN);
    doPadSet = 1'b0;
    doPadGet = 1'b0;
    doInRoute = 1'b0;
    doOutRoute = 1'b0;
    badCmd = 1'b0;
    if (cmdValid) begin
      unique case (cmd.op)
        OP_PAD_SET: begin
          doPadSet = 1'b1;
        end
        OP_PAD_GET: begin
          // A zero or multi-bit mask cannot name a single pin
          doPadGet = selOneHot;
          badCmd = ~selOneHot;
        end
        OP_IN_ROUTE: begin
          doInRoute = selOneHot & inIdxLegal;
          badCmd = ~(selOneHot & inIdxLegal);
        end
        OP_OUT_ROUTE: begin
          // A zero mask is accepted and changes no pin
          doOutRoute = outSelLegal;
          badCmd = ~outSelLegal;
        end
      endcase
    end
    // Only the addressed port sees the mask; other ports keep their state
    pinHit = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (cmd.port == 2'(p)) begin
        pinHit[p*PINS_PER_PORT +: PINS_PER_PORT] = cmd.portPinMask;
      end
    end
  end

  // Per-input pin selection
  // Several inputs may watch the same pin
  psrm_in_sel_t inSel_reg [NUM_IN];
  psrm_in_sel_t inSel_next [NUM_IN];
  logic [NUM_IN-1:0] periphIn_next;

  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      inSel_next[i] = inSel_reg[i];
      if (doInRoute && cmd.data == SEL_W'(i)) begin
        inSel_next[i].port = cmd.port;
        inSel_next[i].pinMask = cmd.portPinMask;
      end
      // An unrouted input reads low
      periphIn_next[i] = 1'b0;
      if (inSel_reg[i].pinMask != 8'h00) begin
        periphIn_next[i] = padSync2_reg[pinNumber(inSel_reg[i].port,
                                                  inSel_reg[i].pinMask)];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_IN; i++) begin
        inSel_reg[i] <= IN_SEL_RESET;
      end
      periphIn_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_IN; i++) begin
        inSel_reg[i] <= inSel_next[i];
      end
      periphIn_reg <= periphIn_next;
    end
  end

  // Pad cells; high-drive pins lack pulls and analog path by construction
  psrm_override_t cmdOvr;
  psrm_override_t padCfg [NUM_PINS];

  always_comb begin
    cmdOvr.outEnForce = cmd.data[OVR_OE_POS];
    cmdOvr.pullupForce = cmd.data[OVR_PUE_POS];
    cmdOvr.pulldownForce = cmd.data[OVR_PDE_POS];
    cmdOvr.analogForce = cmd.data[OVR_ANA_POS];
    cmdOvr.forceOff = cmd.data[OVR_DIS_POS];
  end

  for (genvar g = 0; g < NUM_PINS; g++) begin : gPin
    localparam bit HD = (g / PINS_PER_PORT == int'(HIGH_DRIVE_PORT)) &&
                        (g % PINS_PER_PORT >= HIGH_DRIVE_PIN_FIRST) &&
                        (g % PINS_PER_PORT <= HIGH_DRIVE_PIN_LAST);
    psrm_pad_cell #(
      .HIGH_DRIVE(HD)
    ) uPad (
      .clk(clk),
      .reset_n(reset_n),
      .wrPad(doPadSet & pinHit[g]),
      .wrRoute(doOutRoute & pinHit[g]),
      .cfgIn(cmdOvr),
      .routeIn(cmd.data),
      .periphOut(periphOut),
      .periphOe(periphOe),
      .gpioOut(gpioOut[g]),
      .gpioOe(gpioOe[g]),
      .cfg_reg(padCfg[g]),
      .padOut_reg(padOut[g]),
      .padOeN_reg(padOeN[g]),
      .padPullUp_reg(padPullUp[g]),
      .padPullDown_reg(padPullDown[g]),
      .padAnalog_reg(padAnalog[g])
    );
  end

  // Readback and error reporting
  // Readback shows written bits even where a high-drive pad ignores them
  psrm_override_t rdData_next;
  logic rdValid_next;
  logic cmdErr_next;

  always_comb begin
    rdValid_next = doPadGet;
    cmdErr_next = badCmd;
    rdData_next = rdData_reg;
    if (doPadGet) begin
      rdData_next = padCfg[pinNumber(cmd.port, cmd.portPinMask)];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdValid_reg <= 1'b0;
      rdData_reg <= OVR_RESET;
      cmdErr_reg <= 1'b0;
    end else begin
      rdValid_reg <= rdValid_next;
      rdData_reg <= rdData_next;
      cmdErr_reg <= cmdErr_next;
    end
  end
endmodule

// *** dv/psrm_routing_matrix_checker.sv ***
`timescale 1ns/1ns
module psrm_routing_matrix_checker (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic cmdValid, // Strobe
  input wire psrm_pkg::psrm_cmd_t cmd, // Command
  input wire logic rdValid_reg, // Read valid
  input wire psrm_pkg::psrm_override_t rdData_reg, // Read data
  input wire logic cmdErr_reg, // Refused
  input wire logic [psrm_pkg::NUM_PINS-1:0] padPullUp, // Pull-ups
  input wire logic [psrm_pkg::NUM_PINS-1:0] padPullDown, // Pull-downs
  input wire logic [psrm_pkg::NUM_PINS-1:0] padAnalog // Analog
);
  import psrm_pkg::*;
  logic isGet;
  logic selBad;
  assign isGet = cmdValid && cmd.op == OP_PAD_GET;
  assign selBad = !$onehot(cmd.portPinMask);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_get_ans; isGet && !selBad |=> rdValid_reg && !cmdErr_reg; endproperty
  a_get_ans: assert property (p_get_ans) else $error("no readback");
  property p_sel_bad; cmdValid && cmd.op inside {OP_PAD_GET, OP_IN_ROUTE} && selBad
    |=> cmdErr_reg && !rdValid_reg; endproperty
  a_sel_bad: assert property (p_sel_bad) else $error("bad mask taken");
  property p_in_rng; cmdValid && cmd.op == OP_IN_ROUTE && cmd.data > 5'h14 |=> cmdErr_reg;
  endproperty
  a_in_rng: assert property (p_in_rng) else $error("bad input taken");
  property p_out_rng; cmdValid && cmd.op == OP_OUT_ROUTE && cmd.data > OUT_SEL_MAX
    |=> cmdErr_reg; endproperty
  a_out_rng: assert property (p_out_rng) else $error("bad output taken");
  property p_hd; (padPullUp[19:16] | padPullDown[19:16] | padAnalog[19:16]) == 4'h0; endproperty
  a_hd: assert property (p_hd) else $error("high-drive pull");
  property p_rd_cause; rdValid_reg |-> $past(isGet); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("stray readback");
  property p_rd_hold; !rdValid_reg |-> $stable(rdData_reg); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rst; $rose(reset_n) |-> (padPullUp | padPullDown | padAnalog) == '0; endproperty
  a_rst: assert property (p_rst) else $error("pads not cleared");
endmodule
bind psrm_routing_matrix psrm_routing_matrix_checker u_psrm_routing_matrix_checker (
  .clk(clk), .reset_n(reset_n), .cmdValid(cmdValid), .cmd(cmd), .rdValid_reg(rdValid_reg),
  .rdData_reg(rdData_reg), .cmdErr_reg(cmdErr_reg), .padPullUp(padPullUp),
  .padPullDown(padPullDown), .padAnalog(padAnalog));

// *** dv/psrm_periph_model.sv ***
`timescale 1ns/1ns
module psrm_periph_model (
  input wire logic [psrm_pkg::NUM_OUT-1:0] drvOut, // Peripheral values
  input wire logic [psrm_pkg::NUM_OUT-1:0] drvOe, // Peripheral enables
  input wire logic [psrm_pkg::NUM_PINS-1:0] extLevel, // Off-chip level
  input wire logic [psrm_pkg::NUM_PINS-1:0] padOut, // Pad values
  input wire logic [psrm_pkg::NUM_PINS-1:0] padOeN, // Pad enables
  input wire logic [psrm_pkg::NUM_PINS-1:0] padPullUp, // Pull-ups
  input wire logic [psrm_pkg::NUM_PINS-1:0] padPullDown, // Pull-downs
  output logic [psrm_pkg::NUM_OUT-1:0] periphOut, // To matrix
  output logic [psrm_pkg::NUM_OUT-1:0] periphOe, // To matrix
  output logic [psrm_pkg::NUM_PINS-1:0] padIn // Pad levels
);
  import psrm_pkg::*;
  always_comb begin
    periphOut = drvOut;
    // Enables passed raw: UART lines may show one and the matrix must ignore it
    periphOe = drvOe;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (!padOeN[i]) padIn[i] = padOut[i];
      else if (padPullUp[i]) padIn[i] = 1'b1;
      else if (padPullDown[i]) padIn[i] = 1'b0;
      else padIn[i] = extLevel[i];
    end
  end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  import psrm_pkg::*;
  logic clk, reset_n, cmdValid, rdValid_reg, cmdErr_reg;
  psrm_cmd_t cmd;
  psrm_override_t rdData_reg;
  logic [NUM_PINS-1:0] padIn, gpioOut, gpioOe, padOut, padOeN, padPullUp, padPullDown;
  logic [NUM_PINS-1:0] padAnalog, extLevel;
  logic [NUM_OUT-1:0] periphOut, periphOe, drvOut, drvOe;
  logic [NUM_IN-1:0] periphIn_reg;
  int failures, n_checks;
  psrm_routing_matrix u_psrm_routing_matrix (.clk(clk), .reset_n(reset_n),
    .cmdValid(cmdValid), .cmd(cmd), .rdValid_reg(rdValid_reg), .rdData_reg(rdData_reg),
    .cmdErr_reg(cmdErr_reg), .padIn(padIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .periphOut(periphOut), .periphOe(periphOe), .periphIn_reg(periphIn_reg),
    .padOut(padOut), .padOeN(padOeN), .padPullUp(padPullUp), .padPullDown(padPullDown),
    .padAnalog(padAnalog));
  psrm_periph_model u_psrm_periph_model (.drvOut(drvOut), .drvOe(drvOe),
    .extLevel(extLevel), .padOut(padOut), .padOeN(padOeN), .padPullUp(padPullUp),
    .padPullDown(padPullDown), .periphOut(periphOut), .periphOe(periphOe), .padIn(padIn));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic send(input psrm_op_t op, input logic [1:0] port, input logic [7:0] mask,
                      input logic [4:0] data);
    @(negedge clk);
    cmdValid = 1'b1;
    cmd = '{op: op, port: port, portPinMask: mask, data: data};
    @(negedge clk);
    cmdValid = 1'b0;
  endtask
  // Pad and input paths take up to three edges; four leaves margin
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    failures++;
    report_and_stop;
  end
  initial begin
    failures = 0;
    n_checks = 0;
    reset_n = 1'b0;
    cmdValid = 1'b0;
    cmd = '0;
    gpioOut = 32'h80000000;
    gpioOe = 32'h80000000;
    drvOut = '0;
    drvOe = '0;
    extLevel = '0;
    repeat (8) @(negedge clk);
    chk(padOeN, 32'hffffffff);
    reset_n = 1'b1;
    send(OP_PAD_SET, 2'h0, 8'h09, 5'h02);
    send(OP_PAD_SET, 2'h1, 8'h01, 5'h0e);
    // High-drive pins get forbidden pull bits on purpose: the pads must ignore them
    send(OP_PAD_SET, 2'h2, 8'h0f, 5'h0e);
    settle;
    chk(padPullUp, 32'h00000109);
    chk(padPullDown, 32'h00000100);
    chk(padAnalog, 32'h00000100);
    send(OP_PAD_SET, 2'h2, 8'h01, 5'h01);
    settle;
    chk({padPullUp[16], padOeN[16]}, 32'h0);
    send(OP_PAD_GET, 2'h0, 8'h08, 5'h00);
    chk({rdValid_reg, rdData_reg}, 32'h22);
    send(OP_PAD_GET, 2'h2, 8'h02, 5'h00);
    chk(rdData_reg, 32'h0e);
    send(OP_PAD_GET, 2'h0, 8'h04, 5'h00);
    chk(rdData_reg, 32'h00);
    $display("pad test done");
    drvOut = 21'h000009;
    drvOe = 21'h000009;
    send(OP_OUT_ROUTE, 2'h3, 8'h03, 5'h04);
    send(OP_OUT_ROUTE, 2'h3, 8'h04, 5'h01);
    settle;
    chk(padOut[31:24], 32'h87);
    chk(padOeN[31:24], 32'h7c);
    drvOe = '0;
    send(OP_PAD_SET, 2'h3, 8'h01, 5'h01);
    send(OP_PAD_SET, 2'h3, 8'h02, 5'h13);
    settle;
    chk({padPullUp[25], padOeN[25:24]}, 32'h2);
    drvOe = 21'h000008;
    settle;
    chk(padOeN[25], 32'h0);
    for (int k = 1; k <= NUM_OUT; k++) begin
      drvOut = 21'h1 << (k - 1);
      send(OP_OUT_ROUTE, 2'h3, 8'h08, 5'(k));
      settle;
      chk(padOut[27], 32'h1);
    end
    $display("output test done");
    extLevel = 32'h00000200;
    for (int j = 0; j < NUM_IN; j++) send(OP_IN_ROUTE, 2'h1, 8'h02, 5'(j));
    settle;
    chk(periphIn_reg, 32'h1fffff);
    extLevel = 32'h00000020;
    send(OP_IN_ROUTE, 2'h0, 8'h20, 5'h00);
    settle;
    chk(periphIn_reg, 32'h000001);
    $display("input test done");
    send(OP_PAD_GET, 2'h0, 8'h03, 5'h00);
    chk({cmdErr_reg, rdValid_reg}, 32'h2);
    send(OP_IN_ROUTE, 2'h0, 8'h00, 5'h01);
    chk(cmdErr_reg, 32'h1);
    send(OP_IN_ROUTE, 2'h0, 8'h01, 5'h15);
    chk(cmdErr_reg, 32'h1);
    send(OP_OUT_ROUTE, 2'h3, 8'h01, 5'h16);
    chk(cmdErr_reg, 32'h1);
    settle;
    chk(periphIn_reg, 32'h000001);
    $display("refusal test done");
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    settle;
    chk(padOut[31:24], 32'h80);
    chk(padOeN[31:24], 32'h7f);
    chk(padPullUp | padPullDown | padAnalog, 32'h0);
    chk(periphIn_reg, 32'h0);
    $display("reset test done");
    report_and_stop;
  end
endmodule
